// ==== shared/clr_pkg.sv ====
// Constants, field layouts and carrier types of the charge limit register bank
package clr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register locations
    localparam logic [7:0] CLR_ADDR_CURRENT = 8'h04;
    localparam logic [7:0] CLR_ADDR_SPECIAL = 8'h05;
    localparam logic [7:0] CLR_ADDR_LIMIT = 8'h06;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CLR_RST_CURRENT = 8'h01;
    localparam logic [7:0] CLR_RST_SPECIAL = 8'h04;
    localparam logic [7:0] CLR_RST_LIMIT = 8'h40;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CLR_CHARGER_RESET_BIT = 7;
    localparam int CLR_CHG_HI = 6;
    localparam int CLR_CHG_LO = 4;
    localparam int CLR_TERM_HI = 2;
    localparam int CLR_TERM_LO = 0;
    localparam int CLR_SPARE_HI = 7;
    localparam int CLR_SPARE_LO = 6;
    localparam int CLR_REDUCED_BIT = 5;
    localparam int CLR_PWR_FLAG_BIT = 4;
    localparam int CLR_PIN_LVL_BIT = 3;
    localparam int CLR_VS_HI = 2;
    localparam int CLR_VS_LO = 0;
    localparam int CLR_MCHG_HI = 7;
    localparam int CLR_MCHG_LO = 4;
    localparam int CLR_MREG_HI = 3;
    localparam int CLR_MREG_LO = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Sense voltages in units of 0.1 mV
    localparam logic [10:0] CLR_CHG_OFS = 11'h176;
    localparam logic [10:0] CLR_CHG_STEP = 11'h044;
    localparam logic [10:0] CLR_REDUCED_SENSE = 11'h0dd;
    localparam logic [10:0] CLR_TERM_OFS = 11'h022;
    localparam logic [10:0] CLR_TERM_STEP = 11'h022;
    localparam logic [10:0] CLR_MCHG_OFS = 11'h176;

    ////////////////////////////////////////////////////////////////////////////
    // Voltages in mV
    localparam logic [12:0] CLR_SPEC_OFS = 13'h1068;
    localparam logic [12:0] CLR_SPEC_STEP = 13'h0050;
    localparam logic [12:0] CLR_VREG_OFS = 13'h0dac;
    localparam logic [12:0] CLR_VREG_STEP = 13'h0014;
    localparam logic [12:0] CLR_MREG_OFS = 13'h1068;
    // Limit voltage offset expressed in regulation code steps
    localparam logic [5:0] CLR_MREG_CODE_OFS = 6'((CLR_MREG_OFS - CLR_VREG_OFS) / CLR_VREG_STEP);

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } clr_req_t;

    typedef struct packed {
        logic [10:0] charge_sense;
        logic [10:0] term_sense;
        logic [12:0] special_mv;
        logic [10:0] max_charge_sense;
        logic [12:0] max_reg_mv;
        logic [5:0] reg_code;
        logic [12:0] reg_mv;
    } clr_set_t;

endpackage : clr_pkg

// ==== rtl/clr_sync.sv ====
// Two flip-flop synchroniser, one lane per bit
`timescale 1ns/100ps
module clr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    meta_r[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_r[i] <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate

endmodule : clr_sync

// ==== rtl/clr_bank.sv ====
// Charge current, special voltage and safety limit registers with limit clamping
`timescale 1ns/100ps

// What the document requires of this block and of its host
// RULE1: Writing one to bit 7 at 04h pulses charger reset; reads return zero.
// RULE2: Charge current code is bits 6..4 of 04h in 6.8 mV steps.
// RULE3: Charge sense voltage is 37.4 mV plus the code weights.
// RULE4: Termination code is bits 2..0 of 04h, resetting to 001.
// RULE5: Termination sense voltage is the code weights plus 3.4 mV.
// RULE6: Bit 5 of 05h forces 22.1 mV charge sense; resets to zero.
// RULE7: Bit 4 of 05h reads the input power management flag.
// RULE8: Bit 3 of 05h reads the charge disable pin level.
// RULE9: Special voltage code is bits 2..0 of 05h, resetting to 100.
// RULE10: Special threshold is 4.2 V plus 80 mV per code step.
// RULE11: Maximum charge current code is bits 7..4 of 06h, reset 0100.
// RULE12: Maximum charge sense is 37.4 mV plus code weights.
// RULE13: Maximum regulation code is bits 3..0 of 06h, 4.2 V plus 20 mV steps.
// RULE14: Limit register resets only on the battery short comparator.
// RULE15: Limit register writable until any other register is written.
// RULE16: Regulation voltage and charge current never exceed the limits.
// RULE17: Writing another register first locks the limit reset values.
// RULE18: Host writes the limit register once, before any other register.
// RULE19: Regulation code bits 7..2 of 02h give 3.5 V plus 20 mV steps.
// RULE20: Host sends the register address after the bus address is acknowledged.
// RULE21: Once locked, writes to 06h are ignored until a short reset.
// RULE22: Clamp is the lesser of programmed and limit codes, always current.
module clr_bank (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register access from the serial slave
    input clr_pkg::clr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Code of location 02h, bits 7..2
    input wire logic [5:0] battery_regulation_code,
    // Analog and pin status
    input wire logic charge_disable_pin,
    input wire logic input_power_manage_flag,
    input wire logic battery_short_cmp,
    // Settings to the regulation loops
    output clr_pkg::clr_set_t settings,
    output logic charger_reset,
    output logic limits_locked
);
    import clr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [2:0] pins_s;
    logic dis_pin_s;
    logic pwr_flag_s;
    logic short_s;

    clr_sync #(
        .W(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({battery_short_cmp, input_power_manage_flag, charge_disable_pin}),
        .sync_out(pins_s)
    );

    assign dis_pin_s = pins_s[0];
    assign pwr_flag_s = pins_s[1];
    assign short_s = pins_s[2];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire hit_current = req.addr == CLR_ADDR_CURRENT;
    wire hit_special = req.addr == CLR_ADDR_SPECIAL;
    wire hit_limit = req.addr == CLR_ADDR_LIMIT;
    wire wr_current = req.wr && hit_current;
    wire wr_special = req.wr && hit_special;
    wire wr_other = req.wr && !hit_limit;
    wire charger_reset_req = wr_current && req.wdata[CLR_CHARGER_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [6:0] current_r;
    logic [6:0] current_nxt;
    logic [7:0] special_r;
    logic [7:0] special_nxt;
    logic [7:0] limit_r;
    logic [7:0] limit_nxt;
    logic lock_r;
    logic lock_nxt;

    // Charger reset restores 04h and 05h; the limit register is untouched
    assign current_nxt = charger_reset_req ? CLR_RST_CURRENT[6:0] :
                         wr_current ? req.wdata[6:0] : current_r; // RULE2 RULE4
    assign special_nxt = charger_reset_req ? CLR_RST_SPECIAL :
                         wr_special ? req.wdata : special_r; // RULE6 RULE9

    // Short comparator wins over any write
    assign lock_nxt = short_s ? 1'b0 : (lock_r || wr_other); // RULE15 RULE17
    assign limit_nxt = short_s ? CLR_RST_LIMIT : // RULE14
                       (req.wr && hit_limit && !lock_r) ? req.wdata : // RULE15 RULE21
                       limit_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            current_r <= CLR_RST_CURRENT[6:0];
            special_r <= CLR_RST_SPECIAL;
        end else begin
            current_r <= current_nxt;
            special_r <= special_nxt;
        end
    end

    // Power-on loads the limit register; later only the short comparator resets it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            limit_r <= CLR_RST_LIMIT;
            lock_r <= 1'b0;
        end else begin
            limit_r <= limit_nxt; // RULE14
            lock_r <= lock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fields
    wire [2:0] charge_current_code = current_r[CLR_CHG_HI:CLR_CHG_LO];
    wire [2:0] termination_current_code = current_r[CLR_TERM_HI:CLR_TERM_LO];
    wire reduced_current_select = special_r[CLR_REDUCED_BIT];
    wire [2:0] special_input_voltage_code = special_r[CLR_VS_HI:CLR_VS_LO];
    wire [3:0] max_charge_current_code = limit_r[CLR_MCHG_HI:CLR_MCHG_LO]; // RULE11
    wire [3:0] max_regulation_voltage_code = limit_r[CLR_MREG_HI:CLR_MREG_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Clamping against the safety limits
    wire [3:0] chg_code_ext = {1'b0, charge_current_code};
    wire [3:0] chg_eff = (chg_code_ext < max_charge_current_code) ?
                         chg_code_ext : max_charge_current_code; // RULE16 RULE22
    wire [5:0] reg_limit_code = CLR_MREG_CODE_OFS + {2'b00, max_regulation_voltage_code};
    wire [5:0] reg_eff = (battery_regulation_code < reg_limit_code) ?
                         battery_regulation_code : reg_limit_code; // RULE16 RULE22

    ////////////////////////////////////////////////////////////////////////////
    // Settings arithmetic
    wire [10:0] charge_sense_code = CLR_CHG_OFS + 11'(chg_eff) * CLR_CHG_STEP; // RULE3
    clr_set_t set_nxt;

    assign set_nxt.charge_sense = reduced_current_select ?
                                  CLR_REDUCED_SENSE : charge_sense_code; // RULE6
    assign set_nxt.term_sense = 11'(termination_current_code) * CLR_TERM_STEP
                                + CLR_TERM_OFS; // RULE5
    assign set_nxt.special_mv = CLR_SPEC_OFS
                                + 13'(special_input_voltage_code) * CLR_SPEC_STEP; // RULE10
    assign set_nxt.max_charge_sense = CLR_MCHG_OFS
                                      + 11'(max_charge_current_code) * CLR_CHG_STEP; // RULE12
    assign set_nxt.max_reg_mv = CLR_MREG_OFS
                                + 13'(max_regulation_voltage_code) * CLR_VREG_STEP; // RULE13
    assign set_nxt.reg_code = reg_eff;
    assign set_nxt.reg_mv = CLR_VREG_OFS + 13'(reg_eff) * CLR_VREG_STEP; // RULE19

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [7:0] special_rd;

    always_comb begin
        special_rd = special_r;
        special_rd[CLR_PWR_FLAG_BIT] = pwr_flag_s; // RULE7
        special_rd[CLR_PIN_LVL_BIT] = dis_pin_s; // RULE8
    end

    // Charger reset bit always reads zero
    wire [7:0] rdata_nxt = hit_current ? {1'b0, current_r} : // RULE1
                           hit_special ? special_rd :
                           hit_limit ? limit_r : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= req.rd ? rdata_nxt : rdata;
            rvalid <= req.rd;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            settings <= '0;
            charger_reset <= 1'b0;
            limits_locked <= 1'b0;
        end else begin
            settings <= set_nxt; // RULE22
            charger_reset <= charger_reset_req; // RULE1
            limits_locked <= lock_r;
        end
    end

endmodule : clr_bank

// ==== testbench/clr_bank_asserts.sv ====
// Port checks of the charge limit register bank
`timescale 1ns/100ps
module clr_bank_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register access
    input clr_pkg::clr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // Code and status
    input wire logic [5:0] battery_regulation_code,
    input wire logic charge_disable_pin,
    input wire logic input_power_manage_flag,
    input wire logic battery_short_cmp,
    // Results
    input clr_pkg::clr_set_t settings,
    input wire logic charger_reset,
    input wire logic limits_locked
);
    import clr_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    read_answer_a: assert property (req.rd |=> rvalid) else $error("read not answered");
    reset_pulse_a: assert property (
        req.wr && req.addr == 8'h04 && req.wdata[7] |=> charger_reset ##1 !charger_reset)
        else $error("charger reset pulse wrong");
    reset_bit_zero_a: assert property (
        rvalid && $past(req.addr) == 8'h04 |-> !rdata[7]) else $error("reset bit read high");
    lock_on_write_a: assert property (
        req.wr && req.addr != 8'h06 && !battery_short_cmp && !$past(battery_short_cmp, 2)
        |-> ##2 limits_locked)
        else $error("write did not lock");
    lock_holds_a: assert property (
        limits_locked && !battery_short_cmp && !$past(battery_short_cmp, 3)
        |=> limits_locked) else $error("lock lost");
    reg_clamp_a: assert property (
        $past(nrst) |-> settings.reg_code <= 6'h32
        && settings.reg_code <= $past(battery_regulation_code)
        && settings.reg_mv <= settings.max_reg_mv) else $error("reg code over limit");
    charge_clamp_a: assert property (
        $past(nrst) |-> settings.charge_sense <= settings.max_charge_sense
        || settings.charge_sense == 11'h0dd) else $error("charge over limit");
    special_range_a: assert property (
        $past(nrst) |-> settings.special_mv >= 13'h1068 && settings.special_mv <= 13'h1298
        && settings.special_mv[3:0] == 4'h8) else $error("special voltage off grid");
    max_reg_range_a: assert property (
        $past(nrst) |-> settings.max_reg_mv >= 13'h1068 && settings.max_reg_mv <= 13'h1194)
        else $error("max regulation out of range");
endmodule : clr_bank_asserts
bind clr_bank clr_bank_asserts i_chk (.sys_clk(sys_clk), .nrst(nrst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .battery_regulation_code(battery_regulation_code),
    .charge_disable_pin(charge_disable_pin), .input_power_manage_flag(input_power_manage_flag),
    .battery_short_cmp(battery_short_cmp), .settings(settings),
    .charger_reset(charger_reset), .limits_locked(limits_locked));

// ==== testbench/clr_host.sv ====
// Host model issuing register strobes
`timescale 1ns/100ps
module clr_host (
    // Clock
    input wire logic sys_clk,
    // Register access
    output clr_pkg::clr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import clr_pkg::*;
    initial req = '0;
    // Idle address and data lines show the inverse of the last value
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        put(1'b0, a, 8'h00);
        for (int n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge sys_clk);
        d = rdata;
    endtask : rd
endmodule : clr_host

// ==== testbench/test_clr_bank.sv ====
// Self-checking bench of the charge limit register bank
`timescale 1ns/100ps
module test_clr_bank;
    import clr_pkg::*;
    logic sys_clk, nrst, dis_pin, pwr_flag, short_cmp, rvalid, chg_rst, locked;
    logic [5:0] vreg;
    logic [7:0] rdata, d;
    clr_req_t req;
    clr_set_t st;
    int n_errors = 0, comparisons = 0, cycles = 0;
    clr_host i_host (.sys_clk(sys_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    clr_bank i_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .battery_regulation_code(vreg), .charge_disable_pin(dis_pin),
        .input_power_manage_flag(pwr_flag), .battery_short_cmp(short_cmp), .settings(st),
        .charger_reset(chg_rst), .limits_locked(locked));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        chk("rvalid", {12'h000, rvalid}, 13'h0001);
        chk("rdata", {5'h00, d}, {5'h00, exp});
    endtask : rchk
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    initial begin
        nrst = 1'b0;
        dis_pin = 1'b1;
        pwr_flag = 1'b0;
        short_cmp = 1'b0;
        vreg = 6'h3f;
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        rchk(CLR_ADDR_CURRENT, 8'h01);
        rchk(CLR_ADDR_SPECIAL, 8'h0c);
        rchk(CLR_ADDR_LIMIT, 8'h40);
        chk("term", 13'(st.term_sense), 13'h44);
        chk("special", st.special_mv, 13'h11a8);
        chk("max_chg", 13'(st.max_charge_sense), 13'h286);
        chk("max_reg", st.max_reg_mv, 13'h1068);
        i_host.wr(CLR_ADDR_LIMIT, 8'h9a);
        rchk(CLR_ADDR_LIMIT, 8'h9a);
        chk("max_reg", st.max_reg_mv, 13'h1130);
        chk("max_chg", 13'(st.max_charge_sense), 13'h3da);
        i_host.wr(CLR_ADDR_CURRENT, 8'h7b);
        i_host.wr(CLR_ADDR_LIMIT, 8'h00);
        rchk(CLR_ADDR_LIMIT, 8'h9a);
        rchk(CLR_ADDR_CURRENT, 8'h7b);
        chk("locked", 13'(locked), 13'h1);
        chk("charge", 13'(st.charge_sense), 13'h352);
        chk("term", 13'(st.term_sense), 13'h88);
        chk("reg_code", 13'(st.reg_code), 13'h2d);
        chk("reg_mv", st.reg_mv, 13'h1130);
        i_host.wr(CLR_ADDR_SPECIAL, 8'h21);
        rchk(CLR_ADDR_SPECIAL, 8'h29);
        chk("charge", 13'(st.charge_sense), 13'h0dd);
        chk("special", st.special_mv, 13'h10b8);
        dis_pin = 1'b0;
        pwr_flag = 1'b1;
        repeat (3) @(negedge sys_clk);
        rchk(CLR_ADDR_SPECIAL, 8'h31);
        rchk(8'h07, 8'h00);
        i_host.wr(CLR_ADDR_CURRENT, 8'hff);
        chk("chg_rst", 13'(chg_rst), 13'h1);
        rchk(CLR_ADDR_CURRENT, 8'h01);
        rchk(CLR_ADDR_LIMIT, 8'h9a);
        i_host.wr(CLR_ADDR_CURRENT, 8'h71);
        short_cmp = 1'b1;
        repeat (4) @(negedge sys_clk);
        short_cmp = 1'b0;
        repeat (3) @(negedge sys_clk);
        rchk(CLR_ADDR_LIMIT, 8'h40);
        chk("locked", 13'(locked), 13'h0);
        chk("charge", 13'(st.charge_sense), 13'h286);
        chk("reg_mv", st.reg_mv, 13'h1068);
        i_host.wr(CLR_ADDR_SPECIAL, 8'h04);
        i_host.wr(CLR_ADDR_LIMIT, 8'hff);
        rchk(CLR_ADDR_LIMIT, 8'h40);
        results();
    end
endmodule : test_clr_bank
